// >>> src/erbp_pkg.sv
// Constants and types for the external register bus port
package erbp_pkg;
	localparam int          DATA_W         = 16;
	localparam int          ADDR_W         = 3;
	localparam int          HALF_W         = 8;
	localparam logic [2:0]  RESERVED_SLOT  = 3'h7;

	localparam logic [7:0]  OFF_CTRL       = 8'h00;
	localparam logic [7:0]  OFF_XCMD       = 8'h04;
	localparam logic [7:0]  OFF_XWDATA     = 8'h08;
	localparam logic [7:0]  OFF_XRDATA     = 8'h0C;
	localparam logic [7:0]  OFF_STATUS     = 8'h10;
	localparam logic [7:0]  OFF_GPDIR      = 8'h14;
	localparam logic [7:0]  OFF_GPOUT      = 8'h18;
	localparam logic [7:0]  OFF_GPIN       = 8'h1C;
	localparam logic [7:0]  OFF_SPCFG      = 8'h20;

	// Control register bits
	localparam int          CB_IWS         = 0;
	localparam int          CB_WAITFN      = 1;
	localparam int          CB_GPEN        = 2;
	localparam int          CB_OD          = 3;
	localparam int          CB_HISEL       = 4;
	localparam int          CB_P2DIR       = 5;
	localparam int          CB_P2OUT       = 6;
	localparam int          CTRL_W         = 7;
	localparam logic [6:0]  CTRL_RST       = 7'h00;

	// Command register fields
	localparam int          XC_ADDR_LSB    = 0;
	localparam int          XC_RD          = 3;
	localparam int          XC_INT         = 4;

	// Status register bits
	localparam int          SB_BUSY        = 0;
	localparam int          SB_REFUSED     = 1;

	localparam logic [15:0] HALF_RST       = 16'h0000;
	localparam logic [31:0] WORD_ZERO      = 32'h0000_0000;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_INT  = 4'b0010,
		ST_ACC  = 4'b0100,
		ST_IWS  = 4'b1000
	} erbp_state_t;
endpackage : erbp_pkg

// >>> src/erbp_top.sv
// External register bus port with shared general-purpose port, APB register access
//
// Design decisions made here: the APB register port and the register offsets.
`timescale 1ns/1ps
module erbp_top
	import erbp_pkg::*;
(
	input  wire logic              core_clk_i,
	input  wire logic              arst_n_i,
	input  wire logic [7:0]        paddr_i,
	input  wire logic              psel_i,
	input  wire logic              penable_i,
	input  wire logic              pwrite_i,
	input  wire logic [31:0]       pwdata_i,
	output logic      [31:0]       prdata_o,
	output logic                   pready_o,
	output logic                   pslverr_o,
	output logic      [2:0]        ext_reg_addr_o,
	input  wire logic [15:0]       ext_data_lines_i,
	output logic      [15:0]       ext_data_lines_o,
	output logic      [15:0]       ext_data_lines_oe_o,
	output logic                   transfer_strobe_n_o,
	output logic                   rd_wr_sel_o,
	input  wire logic              third_gp_port_wait_i,
	output logic                   third_gp_port_wait_o,
	output logic                   third_gp_port_wait_oe_o
);
	logic              rst_s1_reg;
	logic              rst_n;

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rst_s1_reg <= 1'b0;
			rst_n      <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_n      <= rst_s1_reg;
		end
	end

	function automatic logic [15:0] od_oe(input logic [15:0] dir, input logic [15:0] val,
		input logic od);
		od_oe = od ? (dir & ~val) : dir;
	endfunction : od_oe

	function automatic logic [15:0] od_val(input logic [15:0] val, input logic od);
		od_val = od ? HALF_RST : val;
	endfunction : od_val

	// Configuration and command registers
	logic [CTRL_W-1:0] ctrl_reg, ctrl_next;
	logic [15:0]       gp_dir_reg, gp_dir_next;
	logic [15:0]       gp_out_reg, gp_out_next;
	logic [15:0]       sp_cfg_reg, sp_cfg_next;
	logic [15:0]       wdata_reg, wdata_next;
	logic [15:0]       rdata_reg, rdata_next;
	logic [2:0]        xaddr_reg, xaddr_next;
	logic              xrd_reg, xrd_next;
	logic              refused_reg, refused_next;
	erbp_state_t       state_reg, state_next;
	logic              pready_reg;
	logic              pslverr_reg, pslverr_next;
	logic [31:0]       prdata_reg, prdata_next;

	logic              wr_go;
	logic              cmd_wr;
	logic              cmd_ok;
	logic              cmd_int;
	logic [2:0]        cmd_addr;
	logic              wait_act;
	logic              busy;
	logic              mapped;
	logic              cmd_bad;

	assign wr_go    = psel_i & penable_i & pready_reg & pwrite_i & ~pslverr_reg;
	assign cmd_addr = pwdata_i[XC_ADDR_LSB +: ADDR_W];
	assign cmd_int  = pwdata_i[XC_INT];
	assign busy     = (state_reg != ST_IDLE);
	assign cmd_wr   = wr_go & (paddr_i == OFF_XCMD);
	assign cmd_ok   = ~busy & (cmd_int | (cmd_addr != RESERVED_SLOT));
	// Refused command reaches its access edge with the error already raised
	assign cmd_bad  = psel_i & penable_i & pready_reg & pwrite_i & pslverr_reg
		& (paddr_i == OFF_XCMD);
	// Wait pin only counts while its function owns the shared pin
	assign wait_act = ctrl_reg[CB_WAITFN] & third_gp_port_wait_i;

	always_comb begin
		ctrl_next    = ctrl_reg;
		gp_dir_next  = gp_dir_reg;
		gp_out_next  = gp_out_reg;
		sp_cfg_next  = sp_cfg_reg;
		wdata_next   = wdata_reg;
		refused_next = refused_reg;
		if (wr_go) begin
			unique case (paddr_i)
				OFF_CTRL:   ctrl_next   = pwdata_i[CTRL_W-1:0];
				OFF_XWDATA: wdata_next  = pwdata_i[DATA_W-1:0];
				OFF_GPDIR:  gp_dir_next = pwdata_i[DATA_W-1:0];
				OFF_GPOUT:  gp_out_next = pwdata_i[DATA_W-1:0];
				OFF_SPCFG:  sp_cfg_next = pwdata_i[DATA_W-1:0];
				OFF_STATUS: refused_next = refused_reg & ~pwdata_i[SB_REFUSED];
				default:    ctrl_next   = ctrl_reg;
			endcase
		end
		if (cmd_bad) begin
			refused_next = 1'b1;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg    <= CTRL_RST;
			gp_dir_reg  <= HALF_RST;
			gp_out_reg  <= HALF_RST;
			sp_cfg_reg  <= HALF_RST;
			wdata_reg   <= HALF_RST;
			refused_reg <= 1'b0;
		end else begin
			ctrl_reg    <= ctrl_next;
			gp_dir_reg  <= gp_dir_next;
			gp_out_reg  <= gp_out_next;
			sp_cfg_reg  <= sp_cfg_next;
			wdata_reg   <= wdata_next;
			refused_reg <= refused_next;
		end
	end

	// Transfer sequencer
	always_comb begin
		state_next = state_reg;
		xaddr_next = xaddr_reg;
		xrd_next   = xrd_reg;
		rdata_next = rdata_reg;
		unique case (state_reg)
			ST_IDLE: begin
				if (cmd_wr & cmd_ok) begin
					xaddr_next = cmd_addr;
					xrd_next   = pwdata_i[XC_RD];
					state_next = cmd_int ? ST_INT : ST_ACC;
				end
			end
			ST_INT: state_next = ST_IDLE;
			ST_ACC: begin
				if (ctrl_reg[CB_IWS]) begin
					state_next = ST_IWS;
				end else if (!wait_act) begin
					state_next = ST_IDLE;
					if (xrd_reg) begin
						rdata_next = ext_data_lines_i;
					end
				end
			end
			ST_IWS: begin
				if (!wait_act) begin
					state_next = ST_IDLE;
					if (xrd_reg) begin
						rdata_next = ext_data_lines_i;
					end
				end
			end
		endcase
	end

	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_IDLE;
			xaddr_reg <= 3'h0;
			xrd_reg   <= 1'b1;
			rdata_reg <= HALF_RST;
		end else begin
			state_reg <= state_next;
			xaddr_reg <= xaddr_next;
			xrd_reg   <= xrd_next;
			rdata_reg <= rdata_next;
		end
	end

	// Pin drivers, computed from next values so outputs track state
	logic        ext_next;
	logic        strobe_n_next;
	logic        rw_next;
	logic [15:0] pdir;
	logic [15:0] pout;
	logic [15:0] pen;
	logic [15:0] ed_o_next;
	logic [15:0] ed_oe_next;
	logic        p2_o_next;
	logic        p2_oe_next;

	always_comb begin
		ext_next      = (state_next == ST_ACC) | (state_next == ST_IWS);
		strobe_n_next = ~ext_next;
		rw_next       = ext_next ? xrd_next : 1'b1;
		pdir          = gp_dir_next;
		pout          = gp_out_next;
		pen           = {DATA_W{ctrl_next[CB_GPEN]}};
		if (ctrl_next[CB_HISEL]) begin
			pdir[DATA_W-1:HALF_W] = sp_cfg_next[HALF_W-1:0];
			pout[DATA_W-1:HALF_W] = sp_cfg_next[DATA_W-1:HALF_W];
			pen[DATA_W-1:HALF_W]  = {HALF_W{1'b1}};
		end
		ed_oe_next = od_oe(pdir & pen, pout, ctrl_next[CB_OD]);
		ed_o_next  = od_val(pout, ctrl_next[CB_OD]) & ed_oe_next;
		if (ext_next & ~xrd_next) begin
			ed_oe_next = {DATA_W{1'b1}};
			ed_o_next  = wdata_next;
		end else if (ext_next) begin
			ed_oe_next = HALF_RST;
			ed_o_next  = HALF_RST;
		end
		p2_oe_next = 1'b0;
		p2_o_next  = 1'b0;
		if (!ctrl_next[CB_WAITFN]) begin
			p2_oe_next = ctrl_next[CB_P2DIR] & ~(ctrl_next[CB_OD] & ctrl_next[CB_P2OUT]);
			p2_o_next  = ctrl_next[CB_P2OUT] & ~ctrl_next[CB_OD] & p2_oe_next;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			ext_reg_addr_o          <= 3'h0;
			transfer_strobe_n_o     <= 1'b1;
			rd_wr_sel_o             <= 1'b1;
			ext_data_lines_o        <= HALF_RST;
			ext_data_lines_oe_o     <= HALF_RST;
			third_gp_port_wait_o    <= 1'b0;
			third_gp_port_wait_oe_o <= 1'b0;
		end else begin
			ext_reg_addr_o          <= xaddr_next;
			transfer_strobe_n_o     <= strobe_n_next;
			rd_wr_sel_o             <= rw_next;
			ext_data_lines_o        <= ed_o_next;
			ext_data_lines_oe_o     <= ed_oe_next;
			third_gp_port_wait_o    <= p2_o_next;
			third_gp_port_wait_oe_o <= p2_oe_next;
		end
	end

	// APB answer, prepared in the setup cycle
	always_comb begin
		mapped = 1'b1;
		prdata_next = WORD_ZERO;
		unique case (paddr_i)
			OFF_CTRL:   prdata_next[CTRL_W-1:0] = ctrl_reg;
			OFF_XCMD:   prdata_next[XC_INT:0]   = {state_reg == ST_INT, xrd_reg, xaddr_reg};
			OFF_XWDATA: prdata_next[DATA_W-1:0] = wdata_reg;
			OFF_XRDATA: prdata_next[DATA_W-1:0] = rdata_reg;
			OFF_STATUS: prdata_next[SB_REFUSED:0] = {refused_reg, busy};
			OFF_GPDIR:  prdata_next[DATA_W-1:0] = gp_dir_reg;
			OFF_GPOUT:  prdata_next[DATA_W-1:0] = gp_out_reg;
			OFF_GPIN:   prdata_next[DATA_W:0]   = {third_gp_port_wait_i, ext_data_lines_i};
			OFF_SPCFG:  prdata_next[DATA_W-1:0] = sp_cfg_reg;
			default:    mapped = 1'b0;
		endcase
		if (!(psel_i & ~penable_i)) begin
			prdata_next = prdata_reg;
		end
		pslverr_next = pslverr_reg;
		if (psel_i & ~penable_i) begin
			pslverr_next = ~mapped | (pwrite_i & (paddr_i == OFF_XCMD) & ~cmd_ok);
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= WORD_ZERO;
		end else begin
			pready_reg  <= 1'b1;
			pslverr_reg <= pslverr_next;
			prdata_reg  <= prdata_next;
		end
	end

	assign prdata_o  = prdata_reg;
	assign pready_o  = pready_reg;
	assign pslverr_o = pslverr_reg;

	// Checks
	addr_on_start_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
		(state_reg == ST_IDLE) && cmd_wr && cmd_ok |=> ext_reg_addr_o == $past(cmd_addr))
		else $error("address not driven for access");
	reserved_slot_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
		!transfer_strobe_n_o |-> ext_reg_addr_o != RESERVED_SLOT)
		else $error("strobe on reserved slot");
	bus_float_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
		(ext_data_lines_oe_o != HALF_RST) |->
		(!transfer_strobe_n_o && !rd_wr_sel_o) || ctrl_reg[CB_GPEN] || ctrl_reg[CB_HISEL])
		else $error("data lines driven without cause");
	strobe_internal_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
		state_reg == ST_INT |-> transfer_strobe_n_o && $stable(transfer_strobe_n_o))
		else $error("strobe active on internal access");
	write_data_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
		!transfer_strobe_n_o && !rd_wr_sel_o |->
		ext_data_lines_oe_o == {DATA_W{1'b1}} && ext_data_lines_o == wdata_reg)
		else $error("write data not valid");
	wait_extends_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
		state_reg == ST_IWS && wait_act |=> !transfer_strobe_n_o)
		else $error("wait not honoured");
	one_iws_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
		$fell(transfer_strobe_n_o) && ctrl_reg[CB_IWS] ##1 !wait_act
		|-> !transfer_strobe_n_o ##1 transfer_strobe_n_o)
		else $error("internal wait state count wrong");
	wait_pin_owner_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
		ctrl_reg[CB_WAITFN] |-> !third_gp_port_wait_oe_o)
		else $error("port drives shared wait pin");
	open_drain_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
		ctrl_reg[CB_OD] && transfer_strobe_n_o |-> (ext_data_lines_o & ext_data_lines_oe_o) == 0)
		else $error("open drain drives high");
	read_capture_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
		!transfer_strobe_n_o && rd_wr_sel_o && !wait_act && !(state_reg == ST_ACC && ctrl_reg[CB_IWS])
		|=> transfer_strobe_n_o && rdata_reg == $past(ext_data_lines_i))
		else $error("read data not captured");
	refused_set_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
		cmd_bad |=> refused_reg)
		else $error("refused command not flagged");
	strobe_external_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
		!transfer_strobe_n_o |-> (state_reg == ST_ACC) || (state_reg == ST_IWS))
		else $error("strobe active outside external transfer");
	read_float_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
		!transfer_strobe_n_o && rd_wr_sel_o |-> ext_data_lines_oe_o == HALF_RST)
		else $error("data lines driven during read");
	addr_hold_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
		!transfer_strobe_n_o && !$fell(transfer_strobe_n_o) |-> $stable(ext_reg_addr_o))
		else $error("address moved during transfer");
	rw_hold_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
		!transfer_strobe_n_o && !$past(transfer_strobe_n_o) |-> $stable(rd_wr_sel_o))
		else $error("direction moved during transfer");
	wait_hold_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
		state_reg == ST_ACC && !ctrl_reg[CB_IWS] && wait_act |=> !transfer_strobe_n_o)
		else $error("wait not honoured in access");
	wait_fn_off_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
		state_reg == ST_ACC && !ctrl_reg[CB_IWS] && !ctrl_reg[CB_WAITFN] |=> transfer_strobe_n_o)
		else $error("wait pin obeyed while port owns it");
	gp_enable_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
		ctrl_reg[CB_GPEN] && !ctrl_reg[CB_OD] && !ctrl_reg[CB_HISEL] && transfer_strobe_n_o |->
		ext_data_lines_oe_o == gp_dir_reg && ext_data_lines_o == (gp_out_reg & gp_dir_reg))
		else $error("port config not on pins");
	upper_byte_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
		ctrl_reg[CB_HISEL] && !ctrl_reg[CB_OD] && transfer_strobe_n_o |->
		ext_data_lines_oe_o[DATA_W-1:HALF_W] == sp_cfg_reg[HALF_W-1:0])
		else $error("upper byte not second port");

	ext_write_c: cover property (@(posedge core_clk_i) disable iff (!rst_n)
		$fell(transfer_strobe_n_o) && !rd_wr_sel_o);
	ext_read_wait_c: cover property (@(posedge core_clk_i) disable iff (!rst_n)
		!transfer_strobe_n_o && rd_wr_sel_o && wait_act ##1 !transfer_strobe_n_o);
	int_access_c: cover property (@(posedge core_clk_i) disable iff (!rst_n)
		state_reg == ST_INT);
	refused_c: cover property (@(posedge core_clk_i) disable iff (!rst_n)
		$rose(refused_reg));
	iws_wait_c: cover property (@(posedge core_clk_i) disable iff (!rst_n)
		state_reg == ST_IWS && wait_act ##1 state_reg == ST_IWS);
endmodule : erbp_top

// >>> bench/erbp_periph_model.sv
// Behavioural peripheral: seven user registers with a programmable wait count
`timescale 1ns/1ps
module erbp_periph_model (
	input  wire logic        clk_i,
	input  wire logic [2:0]  addr_i,
	input  wire logic [15:0] lines_i,
	input  wire logic        strobe_n_i,
	input  wire logic        rw_i,
	output logic      [15:0] lines_o,
	output logic             wait_o
);
	logic [15:0] regs [0:6];
	logic [15:0] last = 16'h0000;
	logic        drive;
	int          nwait = 0;
	int          low_cnt = 0;

	assign drive = !strobe_n_i && rw_i && (addr_i != 3'h7);
	assign lines_o = drive ? regs[addr_i] : ~last;
	assign wait_o = !strobe_n_i && (low_cnt < nwait);

	always @(posedge clk_i) begin
		if (!strobe_n_i) begin
			low_cnt <= low_cnt + 1;
		end
		if (!strobe_n_i && !rw_i && addr_i != 3'h7) begin
			regs[addr_i] <= lines_i;
		end
		if (drive) begin
			last <= lines_o;
		end
	end
endmodule : erbp_periph_model

// >>> bench/erbp_tb_top.sv
// Self-checking bench for the external register bus port
`timescale 1ns/1ps
module erbp_tb_top;
	import erbp_pkg::*;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        psel = 1'b0;
	logic        pen = 1'b0;
	logic        pwr = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata, rd;
	logic        pready, pslverr, err, strobe_n, rw, w_o, w_oe, m_wait;
	logic [2:0]  addr;
	logic [15:0] dout, doe, lines, m_lines;
	int          num_errors = 0;
	int          samples_checked = 0;

	always #20 clk = ~clk;
	assign lines = (doe & dout) | (~doe & m_lines);

	erbp_top dut (.core_clk_i(clk), .arst_n_i(rst_n), .paddr_i(paddr), .psel_i(psel),
		.penable_i(pen), .pwrite_i(pwr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .ext_reg_addr_o(addr),
		.ext_data_lines_i(lines), .ext_data_lines_o(dout), .ext_data_lines_oe_o(doe),
		.transfer_strobe_n_o(strobe_n), .rd_wr_sel_o(rw),
		.third_gp_port_wait_i(w_oe ? w_o : m_wait), .third_gp_port_wait_o(w_o),
		.third_gp_port_wait_oe_o(w_oe));
	erbp_periph_model mdl (.clk_i(clk), .addr_i(addr), .lines_i(lines),
		.strobe_n_i(strobe_n), .rw_i(rw), .lines_o(m_lines), .wait_o(m_wait));

	task automatic end_sim;
		$display("errors %0d, checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : end_sim

	task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask : check

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pen <= 1'b0;
		paddr <= a;
		pwr <= w;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			num_errors++;
			end_sim();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : apb

	task automatic go(input logic [31:0] cmd);
		int n;
		n = 0;
		apb(1'b1, OFF_XCMD, cmd);
		do begin
			apb(1'b0, OFF_STATUS, 32'h0000_0000);
			n++;
		end while (rd[SB_BUSY] !== 1'b0 && n < 20);
		if (n >= 20) begin
			num_errors++;
			end_sim();
		end
		@(negedge clk);
	endtask : go

	task automatic t_write_iws_read;
		apb(1'b1, OFF_XWDATA, 32'h0000_C35A);
		mdl.low_cnt = 0;
		go(32'h0000_0003);
		check("strobe cycles", 32'h0000_0001, mdl.low_cnt);
		check("slot3", 32'h0000_C35A, {16'h0000, mdl.regs[3]});
		check("addr", 32'h0000_0003, {29'h0, addr});
		check("oe idle", 32'h0000_0000, {16'h0000, doe});
		apb(1'b1, OFF_CTRL, 32'h0000_0001);
		mdl.low_cnt = 0;
		go(32'h0000_000B);
		check("iws cycles", 32'h0000_0002, mdl.low_cnt);
		apb(1'b0, OFF_XRDATA, 32'h0000_0000);
		check("xrdata", 32'h0000_C35A, rd);
	endtask : t_write_iws_read

	task automatic t_ext_wait;
		apb(1'b1, OFF_CTRL, 32'h0000_0002);
		@(negedge clk);
		check("wait oe", 32'h0000_0000, {31'h0, w_oe});
		mdl.nwait = 2;
		mdl.low_cnt = 0;
		go(32'h0000_000B);
		check("wait cycles", 32'h0000_0003, mdl.low_cnt);
		mdl.nwait = 0;
		mdl.low_cnt = 0;
		go(32'h0000_0016);
		check("int strobe", 32'h0000_0000, mdl.low_cnt);
		check("int addr", 32'h0000_0006, {29'h0, addr});
	endtask : t_ext_wait

	task automatic t_iws_wait;
		apb(1'b1, OFF_CTRL, 32'h0000_0003);
		mdl.nwait = 2;
		mdl.low_cnt = 0;
		apb(1'b1, OFF_XCMD, 32'h0000_000B);
		apb(1'b1, OFF_XCMD, 32'h0000_0003);
		check("busy err", 32'h0000_0001, {31'h0, err});
		go(32'h0000_0015);
		check("iws wait cycles", 32'h0000_0003, mdl.low_cnt);
		apb(1'b0, OFF_XRDATA, 32'h0000_0000);
		check("wait xrdata", 32'h0000_C35A, rd);
		apb(1'b0, OFF_STATUS, 32'h0000_0000);
		check("busy refused", 32'h0000_0002, rd);
		apb(1'b1, OFF_STATUS, 32'h0000_0002);
		mdl.nwait = 0;
	endtask : t_iws_wait

	task automatic t_refuse;
		apb(1'b1, OFF_XCMD, 32'h0000_0007);
		check("slot7 err", 32'h0000_0001, {31'h0, err});
		apb(1'b0, OFF_STATUS, 32'h0000_0000);
		check("refused", 32'h0000_0002, rd);
		apb(1'b1, OFF_STATUS, 32'h0000_0002);
		apb(1'b0, 8'h40, 32'h0000_0000);
		check("unmapped", 32'h0000_0001, {31'h0, err});
		apb(1'b0, OFF_STATUS, 32'h0000_0000);
		check("cleared", 32'h0000_0000, rd);
	endtask : t_refuse

	task automatic t_port;
		apb(1'b1, OFF_GPDIR, 32'h0000_00FF);
		apb(1'b1, OFF_GPOUT, 32'h0000_00A5);
		apb(1'b1, OFF_CTRL, 32'h0000_0064);
		@(negedge clk);
		check("gp oe", 32'h0000_00FF, {16'h0000, doe});
		check("gp out", 32'h0000_00A5, {24'h0, dout[7:0]});
		check("p2 bit", 32'h0000_0003, {30'h0, w_oe, w_o});
		mdl.low_cnt = 0;
		go(32'h0000_0001);
		check("wait off cycles", 32'h0000_0001, mdl.low_cnt);
		check("slot1", 32'h0000_C35A, {16'h0000, mdl.regs[1]});
		check("gp oe back", 32'h0000_00FF, {16'h0000, doe});
		apb(1'b1, OFF_CTRL, 32'h0000_006C);
		@(negedge clk);
		check("od oe", 32'h0000_005A, {16'h0000, doe});
		apb(1'b1, OFF_SPCFG, 32'h0000_81FF);
		apb(1'b1, OFF_CTRL, 32'h0000_0074);
		@(negedge clk);
		check("hi oe", 32'h0000_FFFF, {16'h0000, doe});
		check("hi out", 32'h0000_0081, {24'h0, dout[15:8]});
		apb(1'b0, OFF_GPIN, 32'h0000_0000);
		check("gp in", 32'h0001_81A5, rd);
	endtask : t_port

	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		t_write_iws_read();
		t_ext_wait();
		t_iws_wait();
		t_refuse();
		t_port();
		end_sim();
	end
endmodule : erbp_tb_top
